// ### dcpr_core.sv
// one channel: test sink, ecc status flags, calibration pattern, refresh watch
// assumes mode register writes and commands arrive synchronous to clk_in
//
// How it works
// - test register writes accepted, then ignored
// - clear bit wipes both flags, self-clears
// - ecc flags stay set until clear
// - second pattern byte resets to 3C, writable
// - first then second byte on dq and dmi
// - each byte sent least significant bit first
// - lane inversion on dq only, never dmi
// - no dmi pattern when read inversion off
// - no bus inversion during calibration
// - refresh independent per channel
`include "dcpr_cfg.svh"

module dcpr_core
	import dcpr_pkg::*;
#(
	parameter int REFW_CYC = `DCPR_REFW_CYC
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// mode register write port
	input  wire dcpr_mrw_s   mrw_in,
	// commands from controller
	input  wire logic        cal_start_in,
	input  wire logic        ref_ab_in,
	input  wire logic        ref_pb_in,
	input  wire logic        self_refresh_exit_in,
	input  wire logic        self_refresh_entry_in,
	input  wire logic        other_cmd_in,
	// ecc engine events
	input  wire logic        ecc_single_in,
	input  wire logic        ecc_double_in,
	// status out
	output logic [7:0]       ecc_status_out,
	// calibration stream
	output dcpr_beat_s       beat_out,
	output logic             beat_valid_out,
	input  wire logic        beat_ready_in,
	// refresh watch
	output logic             refresh_busy_out,
	output logic             rfc_violation_out,
	output logic             extra_refresh_missing_out,
	output logic             window_short_out
);
	// elaboration check: a window must hold every required refresh
	if (REFW_CYC < `DCPR_REF_COUNT) begin : g_refw_chk
		$error("refresh window too short");
	end

	localparam int RFC_W = 3;
	localparam int WIN_W = $clog2(REFW_CYC + 1);
	localparam int RC_W  = 14;

	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0]              pat_first;
		logic [7:0]              pat_second;
		logic [7:0]              inv_lower;
		logic [7:0]              inv_upper;
		logic                    read_inv;
		logic [2:0]              temp_rate;
		logic                    ecc_double;
		logic                    ecc_event;
		dcpr_cal_e               cal;
		logic [`DCPR_BIT_CNT_W-1:0] bit_idx;
		logic [RFC_W-1:0]        rfc_cnt;
		logic                    after_srx;
		logic                    extra_seen;
		logic [WIN_W-1:0]        win_cnt;
		logic [RC_W:0]           ref_cnt;
		logic [7:0]              ecc_status;
		logic                    busy;
		logic                    rfc_viol;
		logic                    extra_miss;
		logic                    win_short;
		dcpr_beat_s              out_beat;
		logic                    out_valid;
	} dcpr_st_s;

	dcpr_st_s   st;
	dcpr_st_s   next_st;
	dcpr_beat_s beat;
	logic       beat_push;
	logic       fifo_ready;
	logic       sel_second;
	logic [2:0] bsel;
	logic       pbit;
	logic       fifo_valid;
	dcpr_beat_s fifo_data;
	logic       out_take;

	// ==========================================================
	// pattern bit selection
	always_comb begin
		sel_second = st.bit_idx[3];
		bsel       = st.bit_idx[2:0];
		pbit       = sel_second ? st.pat_second[bsel] : st.pat_first[bsel];
		beat.dq    = {{8{pbit}} ^ st.inv_upper, {8{pbit}} ^ st.inv_lower};
		beat.data_mask_invert_lane   = st.read_inv ? {2{pbit}} : 2'h0;
		beat.dmi_en = st.read_inv;
		beat_push  = (st.cal == DCPR_SEND);
	end

	// ==========================================================
	// next state
	always_comb begin
		next_st = st;
		// mode register writes
		if (mrw_in.valid) begin
			case (mrw_in.addr)
				`DCPR_MA_PATTERN_FIRST: next_st.pat_first  = mrw_in.data;
				`DCPR_MA_PATTERN_SECND: next_st.pat_second = mrw_in.data;
				`DCPR_MA_LOWER_INV:     next_st.inv_lower  = mrw_in.data;
				`DCPR_MA_UPPER_INV:     next_st.inv_upper  = mrw_in.data;
				`DCPR_MA_IO_CONFIG:     next_st.read_inv = mrw_in.data[`DCPR_IO_READ_INV_BIT];
				`DCPR_MA_TEMP_STATUS:   next_st.temp_rate  = mrw_in.data[2:0];
				`DCPR_MA_TEST_SINK:     next_st = next_st; // accepted, no effect
				default:                next_st = next_st;
			endcase
		end
		// clear first, events after so a same-cycle event wins
		if (mrw_in.valid && mrw_in.addr == `DCPR_MA_ECC
			&& mrw_in.data[`DCPR_ECC_CLEAR_BIT]) begin
			next_st.ecc_double = 1'b0;
			next_st.ecc_event  = 1'b0;
		end
		if (ecc_double_in) next_st.ecc_double = 1'b1;
		if (ecc_single_in || ecc_double_in) next_st.ecc_event = 1'b1;
		// clear bit never stored, reads zero
		next_st.ecc_status = 8'h00;
		next_st.ecc_status[`DCPR_ECC_DOUBLE_BIT] = next_st.ecc_double;
		next_st.ecc_status[`DCPR_ECC_EVENT_BIT]  = next_st.ecc_event;

		// calibration sequencer, stalls on fifo back-pressure
		case (st.cal)
			DCPR_IDLE: begin
				next_st.bit_idx = '0;
				if (cal_start_in) next_st.cal = DCPR_SEND;
			end
			DCPR_SEND: begin
				if (fifo_ready) begin
					next_st.bit_idx = st.bit_idx + 1'b1;
					if (st.bit_idx == 4'hF) next_st.cal = DCPR_DRAIN;
				end
			end
			DCPR_DRAIN: begin
				next_st.cal = DCPR_IDLE;
			end
			default: next_st.cal = DCPR_IDLE;
		endcase

		// refresh cycle time watch for this channel only
		if (st.rfc_cnt != '0) next_st.rfc_cnt = st.rfc_cnt - 1'b1;
		if (st.rfc_cnt != '0 && (other_cmd_in || ref_ab_in || ref_pb_in)) begin
			next_st.rfc_viol = 1'b1;
		end
		// busy spans only the edges at which a command is still too early
		if (ref_ab_in) next_st.rfc_cnt = RFC_W'(`DCPR_RFC_AB_CYC - 1);
		else if (ref_pb_in) next_st.rfc_cnt = RFC_W'(`DCPR_RFC_PB_CYC - 1);
		next_st.busy = (next_st.rfc_cnt != '0);

		// extra refresh between exit and entry
		if (self_refresh_exit_in) begin
			next_st.after_srx  = 1'b1;
			next_st.extra_seen = 1'b0;
		end else if (st.after_srx && (ref_ab_in || ref_pb_in)) begin
			next_st.extra_seen = 1'b1;
		end
		if (self_refresh_entry_in) begin
			if (st.after_srx && !next_st.extra_seen) next_st.extra_miss = 1'b1;
			next_st.after_srx = 1'b0;
		end

		// refresh count per window, saturating so a long window cannot wrap
		if (ref_ab_in && st.ref_cnt < (RC_W+1)'(`DCPR_REF_COUNT)) begin
			next_st.ref_cnt = st.ref_cnt + 1'b1;
		end
		// 1x window unless status allows longer; last-cycle refresh still counts
		if (st.win_cnt == WIN_W'(REFW_CYC - 1)) begin
			if (next_st.ref_cnt < (RC_W+1)'(`DCPR_REF_COUNT)
				&& st.temp_rate <= `DCPR_TEMP_STATUS_RST) begin
				next_st.win_short = 1'b1;
			end
			next_st.win_cnt = '0;
			next_st.ref_cnt = '0;
		end else begin
			next_st.win_cnt = st.win_cnt + 1'b1;
		end

		// output stage: refill when empty or when the sink takes the beat
		out_take = fifo_valid && (!st.out_valid || beat_ready_in);
		if (out_take) begin
			next_st.out_beat  = fifo_data;
			next_st.out_valid = 1'b1;
		end else if (beat_ready_in) begin
			next_st.out_valid = 1'b0;
		end
	end

	// ==========================================================
	// register stage
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st            <= '0;
			st.pat_first  <= `DCPR_PATTERN_FIRST_RST;
			st.pat_second <= `DCPR_PATTERN_SECND_RST;
			st.inv_lower  <= `DCPR_INV_MASK_RST;
			st.inv_upper  <= `DCPR_INV_MASK_RST;
			st.temp_rate  <= `DCPR_TEMP_STATUS_RST;
			st.cal        <= DCPR_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// calibration output buffer
	dcpr_fifo #(
		.WIDTH ($bits(dcpr_beat_s)),
		.DEPTH (16)
	) u_fifo (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.in_valid_in   (beat_push),
		.in_data_in    (beat),
		.in_ready_out  (fifo_ready),
		.out_valid_out (fifo_valid),
		.out_data_out  (fifo_data),
		.out_ready_in  (out_take)
	);

	// ==========================================================
	// outputs, all straight from the state register
	assign beat_out                  = st.out_beat;
	assign beat_valid_out            = st.out_valid;
	assign ecc_status_out            = st.ecc_status;
	assign refresh_busy_out          = st.busy;
	assign rfc_violation_out         = st.rfc_viol;
	assign extra_refresh_missing_out = st.extra_miss;
	assign window_short_out          = st.win_short;
endmodule : dcpr_core

// ### dcpr_cfg.svh
// constants of the calibration pattern / ecc status / refresh block
// assumes one channel, mode register writes arrive as address + 8-bit operand
`ifndef DCPR_CFG_SVH
`define DCPR_CFG_SVH

// ==========================================================
// mode register addresses
`define DCPR_MA_W             6
`define DCPR_MA_IO_CONFIG     6'h03
`define DCPR_MA_TEMP_STATUS   6'h04
`define DCPR_MA_LOWER_INV     6'h0F
`define DCPR_MA_UPPER_INV     6'h14
`define DCPR_MA_PATTERN_FIRST 6'h20
`define DCPR_MA_ECC           6'h21
`define DCPR_MA_TEST_SINK     6'h27
`define DCPR_MA_PATTERN_SECND 6'h28

// ==========================================================
// field positions
`define DCPR_ECC_CLEAR_BIT    5
`define DCPR_ECC_DOUBLE_BIT   1
`define DCPR_ECC_EVENT_BIT    0
`define DCPR_IO_READ_INV_BIT  6

// ==========================================================
// reset values
`define DCPR_PATTERN_FIRST_RST 8'h5A
`define DCPR_PATTERN_SECND_RST 8'h3C
`define DCPR_INV_MASK_RST      8'h00
`define DCPR_IO_CONFIG_RST     8'h00
`define DCPR_TEMP_STATUS_RST   3'h3

// ==========================================================
// refresh timing, 25 MHz clock
`define DCPR_CLK_PERIOD_NS     40
`define DCPR_REFW_MS           32
`define DCPR_REF_COUNT         8192
`define DCPR_RFC_AB_NS         130
`define DCPR_RFC_PB_NS         60
`define DCPR_RFC_AB_CYC ((`DCPR_RFC_AB_NS + `DCPR_CLK_PERIOD_NS - 1) / `DCPR_CLK_PERIOD_NS)
`define DCPR_RFC_PB_CYC ((`DCPR_RFC_PB_NS + `DCPR_CLK_PERIOD_NS - 1) / `DCPR_CLK_PERIOD_NS)
`define DCPR_REFW_CYC   ((`DCPR_REFW_MS * 1000000) / `DCPR_CLK_PERIOD_NS)
`define DCPR_BIT_CNT_W  4

`endif

// ### dcpr_pkg.sv
// types of the calibration pattern / ecc status / refresh block
// assumes dcpr_cfg.svh is compiled with it
package dcpr_pkg;
	`include "dcpr_cfg.svh"

	// ==========================================================
	// mode register write carrier
	typedef struct packed {
		logic                   valid;
		logic [`DCPR_MA_W-1:0]  addr;
		logic [7:0]             data;
	} dcpr_mrw_s;

	// one beat of calibration data: 16 dq lanes and 2 dmi lanes
	typedef struct packed {
		logic [15:0] dq;
		logic [1:0]  data_mask_invert_lane;
		logic        dmi_en;
	} dcpr_beat_s;

	typedef enum logic [1:0] {
		DCPR_IDLE,
		DCPR_SEND,
		DCPR_DRAIN
	} dcpr_cal_e;
endpackage : dcpr_pkg

// ### dcpr_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
module dcpr_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// fill side
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	// drain side
	output logic                  out_valid_out,
	output logic [WIDTH-1:0]      out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	// elaboration check: pointer wrap needs a power-of-two depth
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
		$error("depth must be a power of two");
	end

	// ==========================================================
	// storage and pointers
	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} dcpr_fifo_st_s;

	dcpr_fifo_st_s    st;
	dcpr_fifo_st_s    next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	// honest flags from pointer difference
	always_comb begin
		full         = (st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]);
		empty        = (st.wr == st.rd);
		push         = in_valid_in && !full;
		pop          = out_ready_in && !empty;
		in_ready_out = !full;
		out_valid_out = !empty;
		out_data_out = mem[st.rd[AW-1:0]];
		next_st      = st;
		if (push) next_st.wr = st.wr + 1'b1;
		if (pop) next_st.rd = st.rd + 1'b1;
	end

	// pointer registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// data array, no reset needed
	always_ff @(posedge clk_in) begin
		if (push) mem[st.wr[AW-1:0]] <= in_data_in;
	end
endmodule : dcpr_fifo

// ### dcpr_core_chk.sv
// checker for dcpr_core port behaviour
// assumes bind from the bench top, one clock domain
module dcpr_core_chk
	import dcpr_pkg::*;
#(
	parameter int REFW_CYC = 800000
) (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// requests
	input  wire dcpr_mrw_s  mrw_in,
	input  wire logic       cal_start_in,
	input  wire logic       ref_ab_in,
	input  wire logic       ref_pb_in,
	input  wire logic       self_refresh_exit_in,
	input  wire logic       self_refresh_entry_in,
	input  wire logic       other_cmd_in,
	input  wire logic       ecc_single_in,
	input  wire logic       ecc_double_in,
	// watched outputs
	input  wire logic [7:0] ecc_status_out,
	input  wire dcpr_beat_s beat_out,
	input  wire logic       beat_valid_out,
	input  wire logic       beat_ready_in,
	input  wire logic       refresh_busy_out,
	input  wire logic       rfc_violation_out,
	input  wire logic       extra_refresh_missing_out,
	input  wire logic       window_short_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// ==========================================================
	// helpers: clear write seen, cycles since reset
	logic [31:0] age;
	logic        clr_wr;
	assign clr_wr = mrw_in.valid && mrw_in.addr == 6'h21 && mrw_in.data[5];
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			age <= 32'h0;
		end else if (age < REFW_CYC) begin
			age <= age + 32'h1;
		end
	end
	ab_busy_a: assert property (
		ref_ab_in && !refresh_busy_out |=> refresh_busy_out[*3] ##1 !refresh_busy_out)
		else $error("all-bank busy span wrong");
	pb_busy_a: assert property (
		ref_pb_in && !refresh_busy_out |=> refresh_busy_out[*1] ##1 !refresh_busy_out)
		else $error("per-bank busy span wrong");
	viol_set_a: assert property (
		(ref_ab_in || ref_pb_in || other_cmd_in) && refresh_busy_out |=> rfc_violation_out)
		else $error("command in busy not flagged");
	viol_quiet_a: assert property (
		!refresh_busy_out && !rfc_violation_out |=> !rfc_violation_out)
		else $error("violation flagged outside busy span");
	win_early_a: assert property (window_short_out |-> age >= REFW_CYC - 1)
		else $error("window flag before window end");
	ecc_set_a: assert property (ecc_double_in |=> ecc_status_out[1])
		else $error("double error not recorded");
	ecc_hold_a: assert property (
		!clr_wr |=> &(ecc_status_out[1:0] | ~$past(ecc_status_out[1:0])))
		else $error("ecc flag dropped without clear");
	ecc_clr_a: assert property (
		clr_wr && !ecc_single_in && !ecc_double_in |=> ecc_status_out == 8'h00)
		else $error("ecc clear failed");
	dmi_off_a: assert property (
		beat_valid_out && !beat_out.dmi_en |-> beat_out.data_mask_invert_lane == 2'h0)
		else $error("dmi driven with inversion off");
	beat_hold_a: assert property (
		beat_valid_out && !beat_ready_in |=> beat_valid_out && $stable(beat_out))
		else $error("beat changed while stalled");
	// main scenarios
	cover property (beat_valid_out && !beat_ready_in);
	cover property (clr_wr);
	cover property (ref_pb_in ##1 refresh_busy_out);
endmodule : dcpr_core_chk

// ### dcpr_ctrl_model.sv
// controller model: paces all-bank refreshes, sinks calibration beats
// assumes clock and reset shared with the core
module dcpr_ctrl_model (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// bench controls
	input  wire logic ref_req_in,
	input  wire logic stall_in,
	// to the core
	output logic      ref_ab_out,
	output logic      beat_ready_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] gap;
	logic       phase;
	// one all-bank refresh per 5 cycles, past the busy span
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gap        <= 3'h0;
			phase      <= 1'b0;
			ref_ab_out <= 1'b0;
		end else begin
			phase      <= !phase;
			ref_ab_out <= ref_req_in && gap == 3'h0;
			gap        <= (ref_req_in && gap == 3'h0) ? 3'h4 : (gap != 3'h0 ? gap - 3'h1 : 3'h0);
		end
	end
	// slow sink: while stalled, ready only every other cycle
	assign beat_ready_out = !stall_in || phase;
endmodule : dcpr_ctrl_model

// ### tb_top.sv
// self-checking bench for dcpr_core with controller model
// assumes 25 MHz clock and a 9000-cycle refresh window
module tb_top
	import dcpr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int REFW = 9000;
	logic       clk_in = 1'b0;
	logic       rst_n_in = 1'b0;
	dcpr_mrw_s  mrw = '0;
	logic [6:0] cmd = 7'h00; // double single other entry exit pb cal
	logic       ref_req = 1'b0;
	logic       stall = 1'b0;
	logic       ref_ab, ready, beat_valid, busy, viol, missing, win_short;
	logic [7:0] ecc;
	dcpr_beat_s beat;
	int         fail_count = 0;
	int         comparisons = 0;
	// 40 ns clock
	always #20 clk_in = !clk_in;
	dcpr_core #(.REFW_CYC(REFW)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .mrw_in(mrw),
		.cal_start_in(cmd[0]), .ref_ab_in(ref_ab), .ref_pb_in(cmd[1]),
		.self_refresh_exit_in(cmd[2]), .self_refresh_entry_in(cmd[3]), .other_cmd_in(cmd[4]),
		.ecc_single_in(cmd[5]), .ecc_double_in(cmd[6]), .ecc_status_out(ecc), .beat_out(beat),
		.beat_valid_out(beat_valid), .beat_ready_in(ready), .refresh_busy_out(busy),
		.rfc_violation_out(viol), .extra_refresh_missing_out(missing),
		.window_short_out(win_short));
	dcpr_ctrl_model u_ctrl (.clk_in(clk_in), .rst_n_in(rst_n_in), .ref_req_in(ref_req),
		.stall_in(stall), .ref_ab_out(ref_ab), .beat_ready_out(ready));
	task automatic check(input logic [18:0] got, input logic [18:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask : check
	task automatic mrw_wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_in);
		mrw <= '{1'b1, a, d};
		@(posedge clk_in);
		mrw.valid <= 1'b0;
	endtask : mrw_wr
	task automatic pulse(input logic [6:0] m);
		@(posedge clk_in);
		cmd <= m;
		@(posedge clk_in);
		cmd <= 7'h00;
	endtask : pulse
	// start a calibration read and compare all 16 beats
	task automatic cal(input logic [15:0] pat, input logic [15:0] msk, input logic inv);
		int n;
		n = 0;
		pulse(7'h01);
		for (int t = 0; t < 400 && n < 16; t++) begin
			@(negedge clk_in);
			if (beat_valid === 1'b1 && ready === 1'b1) begin
				check(beat, {{16{pat[n]}} ^ msk, inv ? {2{pat[n]}} : 2'h0, inv});
				n++;
			end
		end
		check(19'(n), 19'h10);
	endtask : cal
	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	// main sequence
	initial begin
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1'b1;
		cal(16'h3C5A, 16'h0000, 1'b0);
		mrw_wr(6'h27, 8'hFF);
		mrw_wr(6'h28, 8'h27);
		mrw_wr(6'h0F, 8'h0F);
		mrw_wr(6'h14, 8'h80);
		mrw_wr(6'h03, 8'h40);
		stall <= 1'b1;
		cal(16'h275A, 16'h800F, 1'b1);
		@(posedge clk_in);
		stall <= 1'b0;
		pulse(7'h60);
		mrw_wr(6'h21, 8'h00);
		@(negedge clk_in);
		check(19'(ecc), 19'h3);
		mrw_wr(6'h21, 8'h20);
		@(negedge clk_in);
		check(19'(ecc), 19'h0);
		// exit, one extra refresh, entry; then exit and entry bare
		pulse(7'h04);
		@(posedge clk_in);
		ref_req <= 1'b1;
		@(posedge clk_in);
		ref_req <= 1'b0;
		// first legal command, four cycles after the refresh
		repeat (4) @(posedge clk_in);
		cmd <= 7'h10;
		@(posedge clk_in);
		cmd <= 7'h00;
		repeat (3) @(posedge clk_in);
		pulse(7'h08);
		@(negedge clk_in);
		check({17'h0, missing, viol}, 19'h0);
		pulse(7'h04);
		pulse(7'h08);
		@(negedge clk_in);
		check(19'(missing), 19'h1);
		// command inside the per-bank busy span
		@(posedge clk_in);
		cmd <= 7'h02;
		@(posedge clk_in);
		cmd <= 7'h10;
		@(posedge clk_in);
		cmd <= 7'h00;
		@(negedge clk_in);
		check(19'(viol), 19'h1);
		check(19'(win_short), 19'h0);
		repeat (REFW) @(posedge clk_in);
		@(negedge clk_in);
		check(19'(win_short), 19'h1);
		end_sim;
	end
	// watchdog: the tests need about 9100 cycles
	initial begin
		repeat (12000) @(posedge clk_in);
		fail_count++;
		end_sim;
	end
endmodule : tb_top

bind dcpr_core dcpr_core_chk #(.REFW_CYC(REFW_CYC)) u_chk (.*);
